// file: hdl/uil_baud_gen.v
// Oversampling tick generator: one tick per sixteenth of a bit
`timescale 1ns/100ps
`default_nettype none
`include "uil_defines.vh"
module uil_baud_gen
#(
    parameter DIV_W = 16
)
(
    input wire mclk_i,
    input wire rst_i,
    input wire [DIV_W-1:0] baud_divider_i,
    output reg ovs_tick_o
);
    reg [DIV_W:0] cnt_reg;
    wire [DIV_W:0] limit = {1'b0, baud_divider_i} + {1'b0, `UIL_BRD_OFFSET} - 17'h00001;

    // Divide by divider plus two; the sixteen ticks make the bit
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_reg <= 17'h00000;
            ovs_tick_o <= 1'b0;
        end
        else if (cnt_reg >= limit)
        begin
            cnt_reg <= 17'h00000;
            ovs_tick_o <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + 17'h00001;
            ovs_tick_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: hdl/uil_core.v
// IrDA encoder/decoder and LIN master header engine of the serial port
`timescale 1ns/100ps
`default_nettype none
`include "uil_defines.vh"
module uil_core
(
    input wire mclk_i,
    input wire rst_i,
    input wire [2:0] function_select_i,
    input wire [15:0] baud_divider_i,
    input wire [1:0] header_select_i,
    input wire [7:0] protected_id_field_i,
    input wire id_parity_hw_enable_i,
    input wire header_send_request_i,
    input wire [3:0] break_length_i,
    input wire [1:0] delimiter_length_i,
    input wire [7:0] interbyte_delay_i,
    input wire bit_error_check_enable_i,
    input wire break_detect_enable_i,
    input wire tx_data_valid_i,
    input wire [7:0] tx_data_i,
    input wire bit_error_clear_i,
    input wire lin_irq_clear_i,
    input wire break_detected_clear_i,
    input wire rx_pin_i,
    output wire tx_data_ready_o,
    output reg header_send_busy_o,
    output reg tx_empty_flag_o,
    output reg bit_error_flag_o,
    output reg break_detected_flag_o,
    output reg lin_irq_flag_o,
    output reg [7:0] rx_data_o,
    output reg rx_available_o,
    output reg tx_pin_o
);
    localparam ST_IDLE = 6'h01;
    localparam ST_BREAK = 6'h02;
    localparam ST_DELIM = 6'h04;
    localparam ST_BYTE = 6'h08;
    localparam ST_GAP = 6'h10;

    wire ovs_tick;
    wire lin_mode = (function_select_i == `UIL_FUNC_LIN);
    wire ir_mode = (function_select_i == `UIL_FUNC_IRDA);

    reg rx_meta_reg;
    reg rx_sync_reg;
    reg [5:0] state_reg;
    reg [3:0] ovs_reg;
    reg [7:0] bitcnt_reg;
    reg [9:0] shift_reg;
    reg [7:0] id_pend_reg;
    reg id_pend_reg_v;
    reg nrz_tx;
    reg [3:0] rx_ovs_reg;
    reg [3:0] rx_bit_reg;
    reg [7:0] rx_shift_reg;
    reg rx_busy_reg;
    reg [4:0] brk_cnt_reg;
    reg [3:0] brk_ovs_reg;
    reg brk_armed_reg;
    reg sync_pend_reg;
    reg rx_idle_seen_reg;
    reg rx_low_seen_reg;

    uil_baud_gen #(.DIV_W(16)) u_baud
    (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .baud_divider_i(baud_divider_i),
        .ovs_tick_o(ovs_tick)
    );

    // Hardware identifier parity from six identifier bits
    function [7:0] uil_pid;
        input [7:0] id;
        input hw;
        begin
            if (hw)
                uil_pid = {~(id[1] ^ id[3] ^ id[4] ^ id[5]),
                    id[0] ^ id[1] ^ id[2] ^ id[4], id[5:0]};
            else
                uil_pid = id;
        end
    endfunction

    // Frame a byte as stop, data, start for LSB-first shifting
    function [9:0] uil_frame;
        input [7:0] d;
        begin
            uil_frame = {1'b1, d, 1'b0};
        end
    endfunction

    // Pin input passes two flops before any logic reads it
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
        end
        else
        begin
            rx_meta_reg <= rx_pin_i;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    // Half duplex: IrDA never accepts data while receiving
    assign tx_data_ready_o = (state_reg == ST_IDLE) && (lin_mode || ir_mode)
        && !(ir_mode && rx_busy_reg);

    wire [7:0] delim_bits = {5'h00, `UIL_DELIM_BASE} + {6'h00, delimiter_length_i};
    wire [7:0] break_bits = {3'h0, `UIL_BREAK_BASE} + {4'h0, break_length_i};
    wire bit_end = ovs_tick && (ovs_reg == `UIL_OVS_LAST);
    wire [7:0] byte_bits = {4'h0, `UIL_DATA_BITS} + 8'h02;

    // Transmit sequencer: break, delimiter, bytes and gaps
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_reg <= ST_IDLE;
            ovs_reg <= 4'h0;
            bitcnt_reg <= 8'h00;
            shift_reg <= 10'h3FF;
            id_pend_reg <= 8'h00;
            id_pend_reg_v <= 1'b0;
            sync_pend_reg <= 1'b0;
            nrz_tx <= 1'b1;
            header_send_busy_o <= 1'b0;
            tx_empty_flag_o <= 1'b1;
        end
        else
        begin
            if (ovs_tick)
                ovs_reg <= ovs_reg + 4'h1;
            case (state_reg)
                ST_IDLE:
                begin
                    nrz_tx <= 1'b1;
                    // Start on a tick so every header bit is exactly sixteen ticks long
                    if (lin_mode && header_send_request_i && !header_send_busy_o && ovs_tick)
                    begin
                        header_send_busy_o <= 1'b1;
                        sync_pend_reg <= (header_select_i != `UIL_HSEL_BREAK);
                        tx_empty_flag_o <= 1'b0;
                        id_pend_reg <= uil_pid(protected_id_field_i, id_parity_hw_enable_i);
                        id_pend_reg_v <= (header_select_i == `UIL_HSEL_FULL);
                        state_reg <= ST_BREAK;
                        bitcnt_reg <= break_bits;
                        ovs_reg <= 4'h0;
                    end
                    else if (tx_data_valid_i && tx_data_ready_o)
                    begin
                        tx_empty_flag_o <= 1'b0;
                        shift_reg <= uil_frame(tx_data_i);
                        bitcnt_reg <= byte_bits;
                        state_reg <= ST_BYTE;
                        ovs_reg <= 4'h0;
                    end
                end
                ST_BREAK:
                begin
                    nrz_tx <= 1'b0;
                    if (bit_end)
                    begin
                        bitcnt_reg <= bitcnt_reg - 8'h01;
                        if (bitcnt_reg == 8'h01)
                        begin
                            state_reg <= ST_DELIM;
                            bitcnt_reg <= delim_bits;
                        end
                    end
                end
                ST_DELIM, ST_GAP:
                begin
                    nrz_tx <= 1'b1;
                    if (bit_end)
                    begin
                        bitcnt_reg <= bitcnt_reg - 8'h01;
                        // Decide at the bit edge, so no idle cycle stretches the line
                        if (bitcnt_reg <= 8'h01)
                        begin
                            if (header_send_busy_o && sync_pend_reg)
                            begin
                                shift_reg <= uil_frame(`UIL_SYNC_BYTE);
                                sync_pend_reg <= 1'b0;
                                bitcnt_reg <= byte_bits;
                                state_reg <= ST_BYTE;
                            end
                            else if (header_send_busy_o && id_pend_reg_v)
                            begin
                                shift_reg <= uil_frame(id_pend_reg);
                                id_pend_reg_v <= 1'b0;
                                bitcnt_reg <= byte_bits;
                                state_reg <= ST_BYTE;
                            end
                            else
                            begin
                                header_send_busy_o <= 1'b0;
                                tx_empty_flag_o <= 1'b1;
                                shift_reg <= 10'h3FF;
                                state_reg <= ST_IDLE;
                            end
                        end
                    end
                end
                ST_BYTE:
                begin
                    nrz_tx <= shift_reg[0];
                    if (bit_end)
                    begin
                        shift_reg <= {1'b1, shift_reg[9:1]};
                        bitcnt_reg <= bitcnt_reg - 8'h01;
                        // Count frame bits; trailing ones must not end the byte early
                        if (bitcnt_reg == 8'h01)
                        begin
                            state_reg <= ST_GAP;
                            bitcnt_reg <= interbyte_delay_i + 8'h01;
                        end
                    end
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // IrDA encoder: pulse in fixed slots 6..8 of sixteen for a zero bit
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            tx_pin_o <= 1'b0;
        else if (ir_mode)
            tx_pin_o <= !nrz_tx && (ovs_reg >= `UIL_IR_PULSE_START)
                && (ovs_reg < `UIL_IR_PULSE_END);
        else
            tx_pin_o <= nrz_tx;
    end

    // IrDA decoder / LIN receiver: high idle, low start, sample mid bit
    wire rx_bit = rx_sync_reg;
    // IrDA pulse is short, so any low since the last sample means zero
    wire rx_nrz = ir_mode ? !(rx_low_seen_reg || !rx_bit) : rx_bit;
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rx_busy_reg <= 1'b0;
            rx_ovs_reg <= 4'h0;
            rx_bit_reg <= 4'h0;
            rx_shift_reg <= 8'h00;
            rx_data_o <= 8'h00;
            rx_available_o <= 1'b0;
            rx_idle_seen_reg <= 1'b0;
            rx_low_seen_reg <= 1'b0;
        end
        else
        begin
            rx_available_o <= 1'b0;
            // A new start needs idle first, so a long break is one character
            if (rx_bit && !rx_busy_reg)
                rx_idle_seen_reg <= 1'b1;
            if (!rx_busy_reg)
            begin
                if (!rx_bit && rx_idle_seen_reg && (ir_mode || lin_mode)
                    && !(ir_mode && state_reg != ST_IDLE))
                begin
                    rx_busy_reg <= 1'b1;
                    rx_idle_seen_reg <= 1'b0;
                    rx_low_seen_reg <= 1'b0;
                    rx_ovs_reg <= 4'h0;
                    rx_bit_reg <= 4'h0;
                end
            end
            else
            begin
                if (!rx_bit)
                    rx_low_seen_reg <= 1'b1;
                if (ovs_tick)
                begin
                    rx_ovs_reg <= rx_ovs_reg + 4'h1;
                    if (rx_ovs_reg == 4'h8)
                    begin
                        rx_low_seen_reg <= 1'b0;
                        rx_bit_reg <= rx_bit_reg + 4'h1;
                        if (rx_bit_reg != 4'h0 && rx_bit_reg <= `UIL_DATA_BITS)
                            rx_shift_reg <= {rx_nrz, rx_shift_reg[7:1]};
                        if (rx_bit_reg == `UIL_DATA_BITS + 4'h1)
                        begin
                            rx_busy_reg <= 1'b0;
                            rx_data_o <= rx_shift_reg;
                            rx_available_o <= 1'b1;
                        end
                    end
                end
            end
        end
    end

    // Break seen: armed, line back high, first tick of the delimiter
    wire brk_hit = break_detect_enable_i && lin_mode && brk_armed_reg && rx_bit && ovs_tick
        && (brk_ovs_reg == 4'h0);

    // Break detector, separate from the receiver above
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            brk_cnt_reg <= 5'h00;
            brk_ovs_reg <= 4'h0;
            brk_armed_reg <= 1'b0;
            break_detected_flag_o <= 1'b0;
        end
        else
        begin
            if (!break_detect_enable_i || !lin_mode || rx_bit)
                brk_ovs_reg <= 4'h0;
            else if (ovs_tick)
            begin
                brk_ovs_reg <= brk_ovs_reg + 4'h1;
                if (brk_ovs_reg == `UIL_OVS_LAST && brk_cnt_reg != 5'h1F)
                    brk_cnt_reg <= brk_cnt_reg + 5'h01;
            end
            if (rx_bit && brk_cnt_reg > `UIL_BRK_DET_MIN)
                brk_armed_reg <= 1'b1;
            if (rx_bit)
                brk_cnt_reg <= 5'h00;
            if (brk_armed_reg && rx_bit && ovs_tick && brk_ovs_reg == 4'h0)
                brk_armed_reg <= 1'b0;
            // Set wins over a clear arriving in the same cycle
            if (brk_hit)
                break_detected_flag_o <= 1'b1;
            else if (break_detected_clear_i && lin_irq_clear_i)
                break_detected_flag_o <= 1'b0;
        end
    end

    // Bit error check: transmit level and synced RX compared at mid-bit of each byte only
    wire bit_err_hit = bit_error_check_enable_i && lin_mode && (state_reg == ST_BYTE)
        && (ovs_reg == 4'h8) && (rx_bit != nrz_tx);
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bit_error_flag_o <= 1'b0;
            lin_irq_flag_o <= 1'b0;
        end
        else
        begin
            if (bit_err_hit)
                bit_error_flag_o <= 1'b1;
            else if (bit_error_clear_i && lin_irq_clear_i)
                bit_error_flag_o <= 1'b0;
            if (bit_err_hit || brk_hit)
                lin_irq_flag_o <= 1'b1;
            else if (lin_irq_clear_i)
                lin_irq_flag_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: hdl/uil_defines.vh
// Constants for the IrDA / LIN master serial port block
`ifndef UIL_DEFINES_VH
`define UIL_DEFINES_VH
`define UIL_FUNC_UART 3'h0
`define UIL_FUNC_LIN 3'h1
`define UIL_FUNC_IRDA 3'h2
`define UIL_HSEL_BREAK 2'h0
`define UIL_HSEL_SYNC 2'h1
`define UIL_HSEL_FULL 2'h2
`define UIL_SYNC_BYTE 8'h55
`define UIL_OVS_LAST 4'hF
`define UIL_IR_PULSE_START 4'h6
`define UIL_IR_PULSE_END 4'h9
`define UIL_BRD_OFFSET 16'h0002
`define UIL_BREAK_BASE 5'h0C
`define UIL_DELIM_BASE 3'h1
`define UIL_BRK_DET_MIN 5'h0B
`define UIL_DATA_BITS 4'h8
`endif

// file: tb/uil_bus_model.sv
// LIN wire and infrared transceiver on the far side of the port
`timescale 1ns/100ps
`default_nettype none
module uil_bus_model (
    input wire logic mclk_i,
    input wire logic tx_pin_i,
    input wire logic ir_mode_i,
    input wire logic force_dom_i,
    output logic rx_pin_o
);
    logic ir_line = 1'b1;
    // Wired bus echoes the master; a forced dominant spoils the echo
    assign rx_pin_o = ir_mode_i ? ir_line : (tx_pin_i & ~force_dom_i);
    // One character, a short low pulse per zero bit, 32 clocks a bit
    task automatic send_ir(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            repeat (12) @(posedge mclk_i);
            #1 ir_line = f[i];
            repeat (6) @(posedge mclk_i);
            #1 ir_line = 1'b1;
            repeat (14) @(posedge mclk_i);
        end
    endtask
endmodule
`default_nettype wire

// file: tb/uil_core_checker.sv
// Assertion checker on the pins of the serial port core
`timescale 1ns/100ps
`default_nettype none
`include "uil_defines.vh"
module uil_core_checker (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [2:0] function_select_i,
    input wire logic [15:0] baud_divider_i,
    input wire logic [3:0] break_length_i,
    input wire logic header_send_request_i,
    input wire logic bit_error_check_enable_i,
    input wire logic break_detect_enable_i,
    input wire logic bit_error_clear_i,
    input wire logic lin_irq_clear_i,
    input wire logic header_send_busy_o,
    input wire logic tx_empty_flag_o,
    input wire logic bit_error_flag_o,
    input wire logic break_detected_flag_o,
    input wire logic lin_irq_flag_o,
    input wire logic rx_available_o,
    input wire logic tx_data_ready_o,
    input wire logic tx_pin_o
);
    int lo_run;
    int hi_run;
    int bitclk;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    assign bitclk = 16 * (baud_divider_i + 2);
    // Run lengths of each transmit level, so widths need no cycle-exact stimulus
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            lo_run <= 0;
            hi_run <= 0;
        end
        else
        begin
            lo_run <= tx_pin_o ? 0 : lo_run + 1;
            hi_run <= tx_pin_o ? hi_run + 1 : 0;
        end
    end
    a_hdr_lin_req: assert property ($rose(header_send_busy_o) |->
        function_select_i == `UIL_FUNC_LIN && $past(header_send_request_i))
        else $error("header started without LIN request");
    a_busy_not_empty: assert property (header_send_busy_o &&
        $past(header_send_busy_o) |-> !tx_empty_flag_o)
        else $error("empty flag during header");
    a_done_empty: assert property ($fell(header_send_busy_o) |-> ##[0:2] tx_empty_flag_o)
        else $error("empty flag missing after header");
    a_break_width: assert property (function_select_i == `UIL_FUNC_LIN &&
        header_send_busy_o && $rose(tx_pin_o) && lo_run > bitclk * 10
        |-> lo_run == bitclk * (12 + break_length_i))
        else $error("break width wrong");
    a_ir_pulse: assert property (function_select_i == `UIL_FUNC_IRDA &&
        $fell(tx_pin_o) && hi_run < bitclk |-> hi_run == 3 * bitclk / 16)
        else $error("infrared pulse width wrong");
    a_half_duplex: assert property (function_select_i == `UIL_FUNC_IRDA &&
        !tx_empty_flag_o |-> !rx_available_o)
        else $error("receive while sending");
    a_biterr_cause: assert property ($rose(bit_error_flag_o) |->
        $past(bit_error_check_enable_i) && function_select_i == `UIL_FUNC_LIN)
        else $error("bit error without check");
    a_biterr_hold: assert property (bit_error_flag_o &&
        !(bit_error_clear_i && lin_irq_clear_i) |=> bit_error_flag_o)
        else $error("bit error flag dropped");
    a_brk_enable: assert property ($rose(break_detected_flag_o) |->
        $past(break_detect_enable_i))
        else $error("break flag while detector off");
    a_irq_follow: assert property ($rose(bit_error_flag_o) ||
        $rose(break_detected_flag_o) |-> ##[0:1] lin_irq_flag_o)
        else $error("interrupt flag missing");
    a_ready_idle: assert property (tx_data_ready_o |-> !header_send_busy_o)
        else $error("data taken during header");
endmodule
`default_nettype wire

// file: tb/uil_core_tb.sv
// Self-checking bench for the serial port core
`timescale 1ns/100ps
`default_nettype none
`include "uil_defines.vh"
module uil_core_tb;
    localparam int BITCLK = 32;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [2:0] fsel = 3'h0;
    logic [1:0] hsel = 2'h0;
    logic [7:0] protected_id_field = 8'h3A;
    logic [3:0] brk_len = 4'h0;
    logic [1:0] dlm_len = 2'h0;
    logic [7:0] gap = 8'h00;
    logic [7:0] td = 8'h00;
    logic hw_par = 1'b0, hreq = 1'b0, bec_en = 1'b1, bd_en = 1'b1, tv = 1'b0;
    logic be_clr = 1'b0, irq_clr = 1'b0, bd_clr = 1'b0, fdom = 1'b0;
    wire rdy, busy, empty, be_flag, bd_flag, irq, rxv, txp, rxp;
    wire [7:0] rxd;
    int n_errors = 0;
    int tests_run = 0;
    uil_core i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .function_select_i(fsel),
        .baud_divider_i(16'h0000), .header_select_i(hsel), .protected_id_field_i(protected_id_field),
        .id_parity_hw_enable_i(hw_par), .header_send_request_i(hreq),
        .break_length_i(brk_len), .delimiter_length_i(dlm_len), .interbyte_delay_i(gap),
        .bit_error_check_enable_i(bec_en), .break_detect_enable_i(bd_en),
        .tx_data_valid_i(tv), .tx_data_i(td), .bit_error_clear_i(be_clr),
        .lin_irq_clear_i(irq_clr), .break_detected_clear_i(bd_clr), .rx_pin_i(rxp),
        .tx_data_ready_o(rdy), .header_send_busy_o(busy), .tx_empty_flag_o(empty),
        .bit_error_flag_o(be_flag), .break_detected_flag_o(bd_flag),
        .lin_irq_flag_o(irq), .rx_data_o(rxd), .rx_available_o(rxv), .tx_pin_o(txp));
    uil_bus_model i_bus (.mclk_i(mclk_i), .tx_pin_i(txp),
        .ir_mode_i(fsel == `UIL_FUNC_IRDA), .force_dom_i(fdom), .rx_pin_o(rxp));
    // 100 MHz clock
    always #5 mclk_i = ~mclk_i;
    task automatic summarize;
        $display("checks %0d, errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask
    // Inputs move 1 ns after the edge so the sampling edge never races them
    task automatic tick(input int k);
        repeat (k) @(posedge mclk_i);
        #1;
    endtask
    task automatic run(input logic lvl, output int n);
        for (n = 0; txp === lvl && n < 5000; n++)
            tick(1);
    endtask
    task automatic clr(input logic b, input logic l, input logic k);
        be_clr = b;
        irq_clr = l;
        bd_clr = k;
        tick(1);
        {be_clr, irq_clr, bd_clr} = 3'h0;
        tick(1);
    endtask
    // Valid and data stand until the edge at which ready is high
    task automatic send(input logic [7:0] b);
        td = b;
        tv = 1'b1;
        for (int n = 0; rdy !== 1'b1 && n < 2000; n++)
            tick(1);
        tick(1);
        tv = 1'b0;
    endtask
    // Samples one LIN byte at bit centres, entered on its start edge
    task automatic get_byte(output logic [7:0] b);
        tick(BITCLK / 2);
        chk(txp === 1'b0, "start bit");
        for (int i = 0; i < 8; i++)
        begin
            tick(BITCLK);
            b[i] = txp;
        end
        tick(BITCLK);
        chk(txp === 1'b1, "stop bit");
        tick(BITCLK / 2);
    endtask
    task automatic t_header(input logic [1:0] hs, input logic hw, input logic [3:0] bl,
        input logic [1:0] dl, input logic [7:0] g);
        int n;
        logic [7:0] b;
        logic p0;
        logic p1;
        p0 = protected_id_field[0] ^ protected_id_field[1] ^ protected_id_field[2] ^ protected_id_field[4];
        p1 = ~(protected_id_field[1] ^ protected_id_field[3] ^ protected_id_field[4] ^ protected_id_field[5]);
        hsel = hs;
        hw_par = hw;
        brk_len = bl;
        dlm_len = dl;
        gap = g;
        hreq = 1'b1;
        run(1'b1, n);
        run(1'b0, n);
        chk(n == BITCLK * (12 + bl) && busy === 1'b1, "break");
        if (hs != 2'h0)
        begin
            run(1'b1, n);
            chk(n == BITCLK * (1 + dl), "delimiter");
            get_byte(b);
            chk(b === `UIL_SYNC_BYTE, "sync byte");
        end
        if (hs == 2'h2)
        begin
            run(1'b1, n);
            chk(n >= BITCLK * (1 + g) - 1 && n <= BITCLK * (1 + g) + 1, "gap");
            get_byte(b);
            chk(b === (hw ? {p1, p0, protected_id_field[5:0]} : protected_id_field), "identifier");
        end
        for (n = 0; busy !== 1'b0 && n < 4000; n++)
            tick(1);
        hreq = 1'b0;
        chk(busy === 1'b0, "send request stuck");
        tick(3);
        chk(empty === 1'b1 && be_flag === 1'b0, "end of header");
        if (hs == 2'h0)
        begin
            tick(BITCLK);
            chk(bd_flag === 1'b1 && irq === 1'b1, "no break flag");
            clr(1'b0, 1'b0, 1'b1);
            chk(bd_flag === 1'b1, "break flag lost");
            clr(1'b0, 1'b1, 1'b1);
            chk(bd_flag === 1'b0, "break flag kept");
            send(`UIL_SYNC_BYTE);
            for (n = 0; rxv !== 1'b1 && n < 12 * BITCLK; n++)
                tick(1);
            chk(rxv === 1'b1 && rxd === `UIL_SYNC_BYTE, "sync echo");
        end
    endtask
    task automatic t_bit_error;
        clr(1'b0, 1'b1, 1'b1);
        send(8'hFF);
        tick(BITCLK * 3);
        fdom = 1'b1;
        tick(BITCLK);
        fdom = 1'b0;
        tick(BITCLK * 10);
        chk(be_flag === 1'b1 && irq === 1'b1, "bit error missed");
        clr(1'b1, 1'b0, 1'b0);
        chk(be_flag === 1'b1, "bit error cleared alone");
        clr(1'b1, 1'b1, 1'b0);
        chk(be_flag === 1'b0, "bit error kept");
    endtask
    task automatic t_irda;
        int k;
        logic prev;
        k = 0;
        prev = 1'b0;
        fsel = `UIL_FUNC_IRDA;
        tick(BITCLK);
        send(8'hA5);
        for (int n = 0; n < 12 * BITCLK; n++)
        begin
            tick(1);
            k += (txp === 1'b1 && prev !== 1'b1);
            prev = txp;
        end
        chk(k == 5 && empty === 1'b1, "pulse count");
        tick(BITCLK * 4);
        fork
            i_bus.send_ir(8'h3C);
        join_none
        for (k = 0; rxv !== 1'b1 && k < 12 * BITCLK; k++)
            tick(1);
        chk(rxv === 1'b1 && rxd === 8'h3C, "infrared receive");
        tick(BITCLK);
    endtask
    // Main sequence
    initial
    begin
        tick(2);
        rst_i = 1'b0;
        tick(2);
        chk(empty === 1'b1 && {busy, be_flag, bd_flag, irq} === 4'h0, "reset");
        fsel = `UIL_FUNC_LIN;
        tick(BITCLK);
        t_header(2'h0, 1'b0, 4'h2, 2'h1, 8'h00);
        t_header(2'h1, 1'b0, 4'h0, 2'h2, 8'h00);
        t_header(2'h2, 1'b1, 4'h0, 2'h0, 8'h02);
        t_header(2'h2, 1'b0, 4'h1, 2'h1, 8'h00);
        t_bit_error;
        t_irda;
        summarize;
    end
    // Watchdog, well beyond the expected run length
    initial
    begin
        #1000000;
        n_errors++;
        summarize;
    end
endmodule
bind uil_core uil_core_checker i_chk (.mclk_i(mclk_i), .rst_i(rst_i),
    .function_select_i(function_select_i), .baud_divider_i(baud_divider_i),
    .break_length_i(break_length_i), .header_send_request_i(header_send_request_i),
    .bit_error_check_enable_i(bit_error_check_enable_i),
    .break_detect_enable_i(break_detect_enable_i), .bit_error_clear_i(bit_error_clear_i),
    .lin_irq_clear_i(lin_irq_clear_i), .header_send_busy_o(header_send_busy_o),
    .tx_empty_flag_o(tx_empty_flag_o), .bit_error_flag_o(bit_error_flag_o),
    .break_detected_flag_o(break_detected_flag_o), .lin_irq_flag_o(lin_irq_flag_o),
    .rx_available_o(rx_available_o), .tx_data_ready_o(tx_data_ready_o), .tx_pin_o(tx_pin_o));
`default_nettype wire
